// ---- rtl/fpar_pkg.sv ----
// Package of constants and types for the flash program register front end
// Notes on behaviour
// - Unlock key register is write-only, reads zero.
// - Key writes form unlock sequence before operations.
// - Whole-array erase ignores the target address.
// - Page erase uses target address as page.
// - Row program uses target address as row.
// - Word program writes data register to target.
// - Data register cleared only by power-on reset.
// - Row data fetched from source address register.
// - Address, data, source registers read/write, reset zero.
// - Trigger starts operation, self-clears when done.
// - Trigger accepted only when allowed and unlocked.
// - Operation select decode; no-ops; protected targets skipped.
// - Failure flag set on unsuccessful operation.
package fpar_pkg;
  localparam int          DW            = 32;
  localparam int          AW            = 4;
  // Word offsets on the register bus
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_KEY       = 4'h1;
  localparam logic [3:0]  OFS_TADDR     = 4'h2;
  localparam logic [3:0]  OFS_DATA      = 4'h3;
  localparam logic [3:0]  OFS_SRC       = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT  = 4'h5;
  localparam logic [3:0]  OFS_IRQ_MASK  = 4'h6;
  // Control register fields
  localparam int          BIT_TRIG      = 15;
  localparam int          BIT_ALLOW     = 14;
  localparam int          BIT_FAIL      = 13;
  localparam int          OP_LSB        = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  // Unlock keys (arbitrary values)
  localparam logic [31:0] KEY_FIRST     = 32'ha5a5_0f0f;
  localparam logic [31:0] KEY_SECOND    = 32'h5a5a_f0f0;
  // Operation codes
  localparam logic [3:0]  OP_NOP0       = 4'h0;
  localparam logic [3:0]  OP_WORD       = 4'h1;
  localparam logic [3:0]  OP_ROW        = 4'h3;
  localparam logic [3:0]  OP_PAGE       = 4'h4;
  localparam logic [3:0]  OP_ALL        = 4'h5;
  // Interrupt status bits
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_FAIL      = 1;
  localparam int          IRQ_W         = 2;

  typedef enum logic [1:0] {
    FPAR_UNLK_IDLE  = 2'b00,
    FPAR_UNLK_KEY1  = 2'b01,
    FPAR_UNLK_OPEN  = 2'b10
  } fpar_unlk_e;

  typedef enum logic [1:0] {
    FPAR_OP_IDLE    = 2'b00,
    FPAR_OP_REQ     = 2'b01,
    FPAR_OP_WAIT    = 2'b10
  } fpar_op_e;

  // Command to the flash array
  typedef struct packed {
    logic        valid;
    logic [3:0]  op;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] src;
  } fpar_cmd_s;

  // Decode: is this code a real operation
  function automatic logic fpar_is_op(input logic [3:0] op);
    return (op == OP_WORD) || (op == OP_ROW) || (op == OP_PAGE) ||
           (op == OP_ALL);
  endfunction
endpackage

// ---- rtl/fpar_data_hold.sv ----
// Program data register kept across every reset except power-on
`timescale 1ns/1ps
module fpar_data_hold (
  input  wire logic              clk,
  input  wire logic              por_n,
  input  wire logic              wr_en,
  input  wire logic [31:0]       wr_data,
  output logic      [31:0]       q
);
  import fpar_pkg::*;

  typedef struct packed {
    logic [31:0] data_reg;
  } fpar_hold_s;

  fpar_hold_s st_reg;
  fpar_hold_s st_next;

  // Only power-on clears; a device reset must not lose the word
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.data_reg = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!por_n) begin
      st_reg <= '{data_reg: REG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.data_reg;
endmodule // fpar_data_hold

// ---- rtl/fpar_regs.sv ----
// Register front end and operation sequencer for program flash
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module fpar_regs (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  por_resetn,
  // Avalon-MM slave
  input  wire logic [fpar_pkg::AW-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic      [1:0]            avs_response,
  output logic                       avs_waitrequest,
  // Flash array side
  output fpar_pkg::fpar_cmd_s        flash_cmd,
  input  wire logic                  flash_done,
  input  wire logic                  flash_error,
  input  wire logic                  flash_protected,
  output logic                       irq
);
  import fpar_pkg::*;

  typedef struct packed {
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  resp_reg;
    fpar_unlk_e  unlk_reg;
    fpar_op_e    op_reg;
    logic        trig_reg;
    logic        allow_reg;
    logic        fail_reg;
    logic [3:0]  sel_reg;
    logic [31:0] taddr_reg;
    logic [31:0] src_reg;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] mask_reg;
    fpar_cmd_s   cmd_reg;
  } fpar_st_s;

  fpar_st_s    st_reg;
  fpar_st_s    st_next;
  logic [31:0] data_q;
  logic        acc;
  logic        wr_acc;
  logic        data_wr;
  logic [31:0] wmask;

  // Bus access takes one wait cycle; ack_reg marks the answer edge
  assign acc     = (avs_read || avs_write) && !st_reg.ack_reg;
  assign wr_acc  = acc && avs_write;
  assign data_wr = wr_acc && (avs_address == OFS_DATA);
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack_reg;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  fpar_data_hold fpar_data_hold_inst (
    .clk     (clk),
    .por_n   (por_resetn),
    .wr_en   (data_wr),
    .wr_data ((data_q & ~wmask) | (avs_writedata & wmask)),
    .q       (data_q)
  );

  // Next state: bus decode, unlock tracker, operation sequencer
  always_comb begin
    logic [31:0] ctrl_rd;
    logic [31:0] wv;
    logic        trig_try;
    st_next = st_reg;
    ctrl_rd = 32'h0000_0000;
    wv      = 32'h0000_0000;
    trig_try = 1'b0;
    st_next.ack_reg = acc;
    ctrl_rd[BIT_TRIG]  = st_reg.trig_reg;
    ctrl_rd[BIT_ALLOW] = st_reg.allow_reg;
    ctrl_rd[BIT_FAIL]  = st_reg.fail_reg;
    ctrl_rd[OP_LSB+:4] = st_reg.sel_reg;
    // Any access other than the expected next step cancels the unlock
    if (acc) begin
      st_next.resp_reg  = 2'b00;
      st_next.rdata_reg = 32'h0000_0000;
      st_next.unlk_reg  = FPAR_UNLK_IDLE;
      if (avs_read) begin
        case (avs_address)
          OFS_CTRL:     st_next.rdata_reg = ctrl_rd;
          OFS_KEY:      st_next.rdata_reg = 32'h0000_0000;
          OFS_TADDR:    st_next.rdata_reg = st_reg.taddr_reg;
          OFS_DATA:     st_next.rdata_reg = data_q;
          OFS_SRC:      st_next.rdata_reg = st_reg.src_reg;
          OFS_IRQ_STAT: st_next.rdata_reg = 32'(st_reg.stat_reg);
          OFS_IRQ_MASK: st_next.rdata_reg = 32'(st_reg.mask_reg);
          default:      st_next.resp_reg  = 2'b10;
        endcase
      end else begin
        case (avs_address)
          OFS_CTRL: begin
            wv = (ctrl_rd & ~wmask) | (avs_writedata & wmask);
            st_next.allow_reg = wv[BIT_ALLOW];
            // Selection is frozen while writes are enabled
            if (!st_reg.allow_reg) begin
              st_next.sel_reg = wv[OP_LSB+:4];
            end
            trig_try = wv[BIT_TRIG] && !st_reg.trig_reg;
            if (trig_try && st_reg.allow_reg &&
                st_reg.unlk_reg == FPAR_UNLK_OPEN) begin
              st_next.trig_reg = 1'b1;
            end
          end
          OFS_KEY: begin
            // Two keys in a row open the gate for one trigger write
            if (avs_writedata == KEY_FIRST) begin
              st_next.unlk_reg = FPAR_UNLK_KEY1;
            end else if (avs_writedata == KEY_SECOND &&
                         st_reg.unlk_reg == FPAR_UNLK_KEY1) begin
              st_next.unlk_reg = FPAR_UNLK_OPEN;
            end
          end
          OFS_TADDR: st_next.taddr_reg =
            (st_reg.taddr_reg & ~wmask) | (avs_writedata & wmask);
          OFS_DATA: ;
          OFS_SRC: st_next.src_reg =
            (st_reg.src_reg & ~wmask) | (avs_writedata & wmask);
          OFS_IRQ_STAT: st_next.stat_reg =
            st_reg.stat_reg & ~avs_writedata[IRQ_W-1:0];
          OFS_IRQ_MASK: st_next.mask_reg = avs_writedata[IRQ_W-1:0];
          default: st_next.resp_reg = 2'b10;
        endcase
      end
    end
    // Operation sequencer
    case (st_reg.op_reg)
      FPAR_OP_IDLE: begin
        if (st_reg.trig_reg) begin
          if (!fpar_is_op(st_reg.sel_reg)) begin
            // A no-op trigger finishes; only OP_NOP0 also clears the failure flag
            st_next.trig_reg = 1'b0;
            st_next.fail_reg = (st_reg.sel_reg == OP_NOP0) ?
                               1'b0 : st_reg.fail_reg;
            st_next.stat_reg[IRQ_DONE] = 1'b1;
          end else begin
            st_next.op_reg        = FPAR_OP_REQ;
            st_next.cmd_reg.valid = 1'b1;
            st_next.cmd_reg.op    = st_reg.sel_reg;
            st_next.cmd_reg.addr  = (st_reg.sel_reg == OP_ALL) ?
              32'h0000_0000 : st_reg.taddr_reg;
            st_next.cmd_reg.data  = data_q;
            st_next.cmd_reg.src   = st_reg.src_reg;
          end
        end
      end
      FPAR_OP_REQ: begin
        // Array raises protected in place of running a guarded target
        st_next.cmd_reg.valid = 1'b0;
        st_next.op_reg        = FPAR_OP_WAIT;
      end
      FPAR_OP_WAIT: begin
        if (flash_done || flash_protected) begin
          st_next.op_reg   = FPAR_OP_IDLE;
          st_next.trig_reg = 1'b0;
          st_next.fail_reg = flash_error;
          st_next.stat_reg[IRQ_DONE] = 1'b1;
          if (flash_error) begin
            st_next.stat_reg[IRQ_FAIL] = 1'b1;
          end
        end
      end
      default: st_next.op_reg = FPAR_OP_IDLE;
    endcase
  end

  // Synchronous device reset; data register lives in its own holder
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg           <= '0;
      st_reg.unlk_reg  <= FPAR_UNLK_IDLE;
      st_reg.op_reg    <= FPAR_OP_IDLE;
      st_reg.taddr_reg <= REG_RESET;
      st_reg.src_reg   <= REG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata_reg;
  assign avs_response = st_reg.resp_reg;
  assign flash_cmd    = st_reg.cmd_reg;
  assign irq          = |(st_reg.stat_reg & st_reg.mask_reg);

  // Trigger completes within a bound once the array answers
  property p_trig_clear;
    @(posedge clk) disable iff (!resetn)
      (st_reg.op_reg == FPAR_OP_WAIT && flash_done) |=> !st_reg.trig_reg;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger not cleared after done");

  property p_key_read_zero;
    @(posedge clk) disable iff (!resetn)
      (acc && avs_read && avs_address == OFS_KEY) |=> avs_readdata == 0;
  endproperty
  a_key_read_zero: assert property (p_key_read_zero)
    else $error("key register read not zero");

  property p_trig_gated;
    @(posedge clk) disable iff (!resetn)
      ($rose(st_reg.trig_reg)) |->
        $past(st_reg.allow_reg) && $past(st_reg.unlk_reg) == FPAR_UNLK_OPEN;
  endproperty
  a_trig_gated: assert property (p_trig_gated)
    else $error("trigger set without unlock");

  property p_all_addr;
    @(posedge clk) disable iff (!resetn)
      (flash_cmd.valid && flash_cmd.op == OP_ALL) |-> flash_cmd.addr == 0;
  endproperty
  a_all_addr: assert property (p_all_addr)
    else $error("erase-all carries an address");

  property p_cmd_fields;
    @(posedge clk) disable iff (!resetn)
      ($rose(flash_cmd.valid) && flash_cmd.op != OP_ALL) |->
        flash_cmd.addr == st_reg.taddr_reg &&
        flash_cmd.src == st_reg.src_reg && flash_cmd.data == data_q;
  endproperty
  a_cmd_fields: assert property (p_cmd_fields)
    else $error("command fields differ from registers");

  sequence s_trig_start;
    st_reg.op_reg == FPAR_OP_IDLE && st_reg.trig_reg &&
    fpar_is_op(st_reg.sel_reg);
  endsequence
  property p_start;
    @(posedge clk) disable iff (!resetn)
      s_trig_start |=> flash_cmd.valid ##1 !flash_cmd.valid;
  endproperty
  a_start: assert property (p_start)
    else $error("operation did not issue one command");

  property p_fail;
    @(posedge clk) disable iff (!resetn)
      (st_reg.op_reg == FPAR_OP_WAIT && flash_done) |=>
        st_reg.fail_reg == $past(flash_error);
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure flag wrong after operation");

  property p_data_hold;
    @(posedge clk) disable iff (!por_resetn)
      (!resetn && !data_wr) |=> data_q == $past(data_q);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data register lost on device reset");

  property p_wait_one;
    @(posedge clk) disable iff (!resetn)
      (acc) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer later than one cycle");

  // Busy flag stays up until the array answers
  property p_trig_hold;
    @(posedge clk) disable iff (!resetn)
      (st_reg.op_reg == FPAR_OP_WAIT && !flash_done && !flash_protected)
        |=> st_reg.trig_reg;
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger dropped while array busy");

  // Completion sets the sticky done bit even against a clear write
  property p_done_stat;
    @(posedge clk) disable iff (!resetn)
      (st_reg.op_reg == FPAR_OP_WAIT && (flash_done || flash_protected))
        |=> st_reg.stat_reg[IRQ_DONE];
  endproperty
  a_done_stat: assert property (p_done_stat)
    else $error("done status not set on completion");

  property p_fail_stat;
    @(posedge clk) disable iff (!resetn)
      (st_reg.op_reg == FPAR_OP_WAIT && flash_done && flash_error)
        |=> st_reg.stat_reg[IRQ_FAIL];
  endproperty
  a_fail_stat: assert property (p_fail_stat)
    else $error("fail status not set on error");

  // Operation select must not move while the allow bit is set
  property p_sel_frozen;
    @(posedge clk) disable iff (!resetn)
      (wr_acc && avs_address == OFS_CTRL && st_reg.allow_reg)
        |=> $stable(st_reg.sel_reg);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen)
    else $error("operation select changed while allowed");

  // Anything but a key write closes the gate again
  sequence s_other_access;
    acc && !(avs_write && avs_address == OFS_KEY);
  endsequence
  property p_key_cancel;
    @(posedge clk) disable iff (!resetn)
      s_other_access |=> st_reg.unlk_reg == FPAR_UNLK_IDLE;
  endproperty
  a_key_cancel: assert property (p_key_cancel)
    else $error("unlock survived another access");

  property p_unlock_open;
    @(posedge clk) disable iff (!resetn)
      (wr_acc && avs_address == OFS_KEY && avs_writedata == KEY_SECOND &&
       st_reg.unlk_reg == FPAR_UNLK_KEY1)
        |=> st_reg.unlk_reg == FPAR_UNLK_OPEN;
  endproperty
  a_unlock_open: assert property (p_unlock_open)
    else $error("second key did not open the gate");

  // No-op codes finish at once and never reach the array
  sequence s_nop_start;
    st_reg.op_reg == FPAR_OP_IDLE && st_reg.trig_reg &&
    !fpar_is_op(st_reg.sel_reg);
  endsequence
  property p_nop_end;
    @(posedge clk) disable iff (!resetn)
      s_nop_start |=> !st_reg.trig_reg && !flash_cmd.valid;
  endproperty
  a_nop_end: assert property (p_nop_end)
    else $error("no-op code reached the array");

  property p_src_write;
    @(posedge clk) disable iff (!resetn)
      (wr_acc && avs_address == OFS_SRC && avs_byteenable == 4'hf)
        |=> st_reg.src_reg == $past(avs_writedata);
  endproperty
  a_src_write: assert property (p_src_write)
    else $error("source address write lost");

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
      (acc && avs_address > OFS_IRQ_MASK) |=> avs_response == 2'b10;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  // Power-on always wins over the held program word
  property p_data_por;
    @(posedge clk) (!por_resetn) |=> data_q == REG_RESET;
  endproperty
  a_data_por: assert property (p_data_por)
    else $error("data register not cleared by power-on");

  property p_cmd_pulse;
    @(posedge clk) disable iff (!resetn)
      flash_cmd.valid |=> !flash_cmd.valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command valid longer than one cycle");
endmodule // fpar_regs

// ---- tb/fpar_flash_model.sv ----
// Behavioural program flash array that answers sequencer commands
`timescale 1ns/1ps
module fpar_flash_model (
  input  wire logic                clk,
  input  wire fpar_pkg::fpar_cmd_s cmd,
  input  wire logic [1:0]          mode,
  input  wire logic [3:0]          lat,
  output logic                     done,
  output logic                     err,
  output logic                     prot,
  output fpar_pkg::fpar_cmd_s      seen,
  output int                       cmds
);
  import fpar_pkg::*;
  int cnt = -1;
  initial begin
    done = 0;
    err = 0;
    prot = 0;
    seen = '0;
    cmds = 0;
  end
  // Busy for lat cycles, then one answer pulse; mode 1 fails, 2 protected
  always @(posedge clk) begin
    done <= 0;
    err <= 0;
    prot <= 0;
    if (cmd.valid) begin
      seen <= cmd;
      cmds <= cmds + 1;
      cnt <= int'(lat);
    end else if (cnt == 0) begin
      prot <= (mode == 2'h2);
      done <= (mode != 2'h2);
      err <= (mode == 2'h1);
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // fpar_flash_model

// ---- tb/fpar_regs_tb.sv ----
// Self-checking bench for the flash program register front end
`timescale 1ns/1ps
module fpar_regs_tb;
  import fpar_pkg::*;
  logic        clk = 0;
  logic        resetn = 0;
  logic        por_resetn = 0;
  logic [3:0]  adr = 0;
  logic        rd = 0;
  logic        wr = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic        wreq;
  fpar_cmd_s   cmd;
  fpar_cmd_s   seen;
  logic        done;
  logic        ferr;
  logic        fprot;
  logic        irq;
  logic [1:0]  mode = 0;
  logic [3:0]  lat = 0;
  logic [31:0] q;
  logic [1:0]  rsp;
  logic [31:0] rnd = 32'h8;
  logic [31:0] tmp;
  logic [3:0]  be = 4'hf;
  int          cmds;
  int          ncmd = 0;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          ex[8] = '{default: 0}; // Expected register contents
  logic [3:0]  ops[6] = '{OP_WORD, OP_ROW, OP_PAGE, OP_ALL, 4'h2, 4'h6};

  fpar_regs fpar_regs_inst (.clk(clk), .resetn(resetn),
    .por_resetn(por_resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_response(resp), .avs_waitrequest(wreq),
    .flash_cmd(cmd), .flash_done(done), .flash_error(ferr),
    .flash_protected(fprot), .irq(irq));
  fpar_flash_model fpar_flash_model_inst (.clk(clk), .cmd(cmd),
    .mode(mode), .lat(lat), .done(done), .err(ferr), .prot(fprot),
    .seen(seen), .cmds(cmds));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rsp = resp;
    wr <= 0;
    rd <= 0;
    if (n >= 50) mismatches++;
    if (w && a >= OFS_TADDR && a <= OFS_SRC) ex[a] = d;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 0);
    check(q, e);
    check(32'(rsp), 32'h0);
  endtask

  task automatic fill();
    for (int a = 2; a < 5; a++) begin
      bus(1, 4'(a), rnd);
      rnd = lfsr(rnd);
    end
  endtask

  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'(e));
  endtask

  // Unlock, trigger, poll until the trigger drops, compare the command
  task automatic run_op(input logic [3:0] op, input logic [1:0] m);
    int n;
    mode <= m;
    lat <= rnd[3:0];
    rnd = lfsr(rnd);
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_CTRL, 32'(op));
    bus(1, OFS_CTRL, 32'h4000 | 32'(op));
    bus(1, OFS_KEY, KEY_FIRST);
    bus(1, OFS_KEY, KEY_SECOND);
    bus(1, OFS_CTRL, 32'hc000 | 32'(op));
    n = 0;
    do begin
      bus(0, OFS_CTRL, 0);
      n++;
    end while (q[BIT_TRIG] !== 1'b0 && n < 40);
    check(32'(q[BIT_TRIG]), 0);
    check(32'(q[BIT_FAIL]), 32'(m == 2'h1));
    if (op inside {OP_WORD, OP_ROW, OP_PAGE, OP_ALL}) begin
      ncmd++;
      check(32'(seen.op), 32'(op));
      check(seen.addr, (op == OP_ALL) ? 0 : ex[2]);
      check(seen.data, ex[3]);
      check(seen.src, ex[4]);
    end
    check(32'(cmds), 32'(ncmd));
  endtask

  task automatic give_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cut a hang well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    por_resetn <= 1;
    for (int a = 0; a < 5; a++) rdchk(4'(a), 0);
    bus(1, OFS_KEY, rnd);
    fill();
    for (int a = 1; a < 5; a++) rdchk(4'(a), ex[a]);
    bus(0, 4'hf, 0);
    check(32'(rsp), 32'h2);
    // Low half only: upper source bits must keep their old value
    tmp = ex[4];
    be <= 4'h3;
    bus(1, OFS_SRC, ~tmp);
    be <= 4'hf;
    ex[4] = {tmp[31:16], ~tmp[15:0]};
    rdchk(OFS_SRC, ex[4]);
    // All four real operation codes and no-op codes 2 and 6, fresh random operands each time
    bus(1, OFS_IRQ_MASK, 32'h3);
    foreach (ops[i]) begin
      fill();
      run_op(ops[i], 2'h0);
    end
    irqchk(1);
    bus(1, OFS_IRQ_MASK, 0);
    irqchk(0);
    bus(1, OFS_IRQ_MASK, 32'h3);
    irqchk(1);
    bus(1, OFS_IRQ_STAT, 32'h3);
    irqchk(0);
    // A read between the keys, then no keys at all: trigger ignored
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_CTRL, 32'(OP_WORD));
    bus(1, OFS_CTRL, 32'h4001);
    bus(1, OFS_KEY, KEY_FIRST);
    bus(0, OFS_DATA, 0);
    bus(1, OFS_KEY, KEY_SECOND);
    bus(1, OFS_CTRL, 32'hc001);
    rdchk(OFS_CTRL, 32'h4001);
    bus(1, OFS_CTRL, 32'hc001);
    rdchk(OFS_CTRL, 32'h4001);
    check(32'(cmds), 32'(ncmd));
    run_op(OP_PAGE, 2'h2);
    run_op(OP_WORD, 2'h1);
    rdchk(OFS_IRQ_STAT, 32'h3);
    irqchk(1);
    run_op(OP_NOP0, 2'h0);
    // Device reset keeps program data; power-on reset clears it
    resetn <= 0;
    repeat (3) @(posedge clk);
    resetn <= 1;
    rdchk(OFS_DATA, ex[3]);
    rdchk(OFS_TADDR, 0);
    resetn <= 0;
    por_resetn <= 0;
    repeat (3) @(posedge clk);
    resetn <= 1;
    por_resetn <= 1;
    rdchk(OFS_DATA, 0);
    give_verdict();
  end
endmodule // fpar_regs_tb
